// [ssps_pkg.sv]
/*
 * package for the synchronous serial port: register map, field positions,
 * reset values, timing counts and the shared types.
 * assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package ssps_pkg;
	// byte offsets on the register bus
	localparam logic [4:0] SSPS_OFF_STATUS = 5'h00;
	localparam logic [4:0] SSPS_OFF_CTRL1 = 5'h04;
	localparam logic [4:0] SSPS_OFF_CTRL2 = 5'h08;
	localparam logic [4:0] SSPS_OFF_DATA = 5'h0C;
	localparam logic [4:0] SSPS_OFF_IRQ_STAT = 5'h10;
	localparam logic [4:0] SSPS_OFF_IRQ_EN = 5'h14;
	localparam logic [4:0] SSPS_OFF_IRQ_CLR = 5'h18;
	// serial_port_status fields
	localparam int SSPS_ST_SAMPLE = 7;
	localparam int SSPS_ST_EDGE = 6;
	localparam int SSPS_ST_DATA = 5;
	localparam int SSPS_ST_STOP = 4;
	localparam int SSPS_ST_START = 3;
	localparam int SSPS_ST_RDWR = 2;
	localparam int SSPS_ST_UPDADDR = 1;
	localparam int SSPS_ST_FULL = 0;
	// control 1 fields; control 2 is general-call enable and own address
	localparam int SSPS_C1_ENABLE = 0;
	localparam int SSPS_C1_I2C = 1;
	localparam int SSPS_C1_MASTER = 2;
	localparam int SSPS_C1_POL = 3;
	localparam int SSPS_C2_GCALL = 7;
	// interrupt event bits
	localparam int SSPS_IRQ_DONE = 0;
	localparam int SSPS_IRQ_START = 1;
	localparam int SSPS_IRQ_STOP = 2;
	localparam int SSPS_IRQ_ARBL = 3;
	localparam int SSPS_IRQ_NACK = 4;
	// reset values
	localparam logic [7:0] SSPS_STATUS_RST = 8'h00;
	localparam logic [7:0] SSPS_CTRL2_RST = 8'h00;
	// serial clock made in master modes
	localparam int SSPS_CLK_MHZ = 200;
	localparam int SSPS_SCK_PERIOD_NS = 400;
	localparam logic [5:0] SSPS_HALF_CYC = 6'((SSPS_SCK_PERIOD_NS * SSPS_CLK_MHZ / 1000) / 2);
	// index of the final half period of a transfer
	localparam logic [4:0] SSPS_LAST_SPI = 5'h0F;
	localparam logic [4:0] SSPS_LAST_SPI_E = 5'h10;
	localparam logic [4:0] SSPS_LAST_I2C = 5'h11;

	typedef enum logic [1:0] {SSPS_IDLE, SSPS_START, SSPS_SHIFT, SSPS_STOP} ssps_fsm_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] addr;
		logic be0;
		logic [7:0] wdata;
	} ssps_av_req_t;

	typedef struct packed {
		ssps_fsm_t fsm;
		logic [7:0] stat;
		logic en;
		logic i2c;
		logic master;
		logic clk_pol;
		logic [7:0] ctrl2;
		logic [4:0] irq_st;
		logic [4:0] irq_en;
		logic [8:0] tx_sh;
		logic [8:0] rx_sh;
		logic [7:0] rx_buf;
		logic [4:0] h;
		logic [5:0] div;
		logic [3:0] nsamp;
		logic sck;
		logic sdo;
		logic sl_act;
		logic sl_addr;
		logic sl_ack;
		logic [3:0] sl_cnt;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [1:0] sdi_s;
		logic ack;
		logic [31:0] rdata;
	} ssps_state_t;
endpackage : ssps_pkg

// [ssps_port.sv]
/*
 * synchronous serial port: one shift engine serving SPI and I2C, the
 * status and control registers, and an Avalon-MM slave with waitrequest.
 * assumes serial pins come from outside the clock domain; open-drain
 * pins are resolved outside from the output enables.
 */
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
// Function
// - one protocol at a time, SPI or I2C, sharing one shift engine
// - I2C master, multi-master and slave in hardware, slave answers general call
// - SPI master samples input mid bit when sample bit 0, at end when 1
// - idle low clock: edge bit 1 shifts on rising edge, 0 on falling
// - status holds eight fields, top two writable, all reset to zero
// - one status and two control registers for software
// - stop flag set by last stop, zero at reset, cleared on disable
// - start flag set by last start, zero at reset, cleared on disable
`timescale 1ns/1ps
module ssps_port import ssps_pkg::*; (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic IRQ,
	input wire logic SCK_SCL_IN,
	output logic SCK_SCL_OUT,
	output logic SCK_SCL_OE,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic SDI,
	output logic SDO,
	output logic SDO_OE
);

	function automatic logic hit(input ssps_av_req_t q, input logic [4:0] off);
		hit = q.wr & q.be0 & (q.addr == off);
	endfunction : hit

	ssps_state_t r;
	ssps_state_t n;
	ssps_av_req_t req;
	logic [4:0] iset;
	logic [8:0] rx_new;
	logic commit, scl_h, scl_rise, scl_fall, sda_rise, sda_fall;
	logic start_det, stop_det, din, tick, cke_e, late_e, bnd, first, samp;
	logic [4:0] last_h;
	logic out_e, in_e, match;

	assign req = '{AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_BYTEENABLE[0], AVS_WRITEDATA[7:0]};
	assign commit = (req.rd | req.wr) & r.ack;

	// second and third stages only: the first stage feeds nothing else
	assign scl_h = r.scl_s[1];
	assign scl_rise = r.scl_s[1] & ~r.scl_s[2];
	assign scl_fall = ~r.scl_s[1] & r.scl_s[2];
	assign sda_rise = r.sda_s[1] & ~r.sda_s[2];
	assign sda_fall = ~r.sda_s[1] & r.sda_s[2];
	assign start_det = scl_h & r.scl_s[2] & sda_fall;
	assign stop_det = scl_h & r.scl_s[2] & sda_rise;
	assign din = r.i2c ? r.sda_s[1] : r.sdi_s[1];

	assign tick = (r.div == SSPS_HALF_CYC - 6'h01);
	assign cke_e = ~r.i2c & r.stat[SSPS_ST_EDGE];
	// I2C reads the line at the end of the high half
	assign late_e = r.i2c | r.stat[SSPS_ST_SAMPLE];
	assign bnd = r.h[0] ^ cke_e;
	assign first = cke_e & (r.h == 5'h00);
	assign last_h = r.i2c ? SSPS_LAST_I2C : (cke_e ? SSPS_LAST_SPI_E : SSPS_LAST_SPI);
	assign samp = late_e ? (bnd & ~first) : ~bnd;
	assign rx_new = samp ? {r.rx_sh[7:0], din} : r.rx_sh;

	// slave edges: shift out on rising when edge bit differs from polarity
	assign out_e = (r.stat[SSPS_ST_EDGE] ^ r.clk_pol) ? scl_rise : scl_fall;
	assign in_e = (r.stat[SSPS_ST_EDGE] ^ r.clk_pol) ? scl_fall : scl_rise;
	assign match = (r.rx_sh[7:1] == r.ctrl2[6:0])
		| (r.ctrl2[SSPS_C2_GCALL] & (r.rx_sh[7:1] == 7'h00));

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = r;
		iset = 5'h00;
		n.scl_s = {r.scl_s[1:0], SCK_SCL_IN};
		n.sda_s = {r.sda_s[1:0], SDA_IN};
		n.sdi_s = {r.sdi_s[0], SDI};
		n.ack = (req.rd | req.wr) & ~r.ack;

		// bus: read data captured the cycle before it is presented
		if ((req.rd | req.wr) & ~r.ack) begin
			case (req.addr)
				SSPS_OFF_STATUS: n.rdata = {24'h000000, r.stat};
				SSPS_OFF_CTRL1: n.rdata = {28'h0000000, r.clk_pol, r.master, r.i2c, r.en};
				SSPS_OFF_CTRL2: n.rdata = {24'h000000, r.ctrl2};
				SSPS_OFF_DATA: n.rdata = {24'h000000, r.rx_buf};
				SSPS_OFF_IRQ_STAT: n.rdata = {27'h0000000, r.irq_st};
				SSPS_OFF_IRQ_EN: n.rdata = {27'h0000000, r.irq_en};
				default: n.rdata = 32'h00000000;
			endcase
		end
		if (commit) begin
			if (hit(req, SSPS_OFF_STATUS)) begin
				n.stat[7:6] = req.wdata[7:6];
			end
			if (hit(req, SSPS_OFF_CTRL1)) begin
				n.en = req.wdata[SSPS_C1_ENABLE];
				n.i2c = req.wdata[SSPS_C1_I2C];
				n.master = req.wdata[SSPS_C1_MASTER];
				n.clk_pol = req.wdata[SSPS_C1_POL];
			end
			if (hit(req, SSPS_OFF_CTRL2)) begin
				n.ctrl2 = req.wdata;
			end
			if (hit(req, SSPS_OFF_IRQ_EN)) begin
				n.irq_en = req.wdata[4:0];
			end
			if (hit(req, SSPS_OFF_IRQ_CLR)) begin
				n.irq_st = r.irq_st & ~req.wdata[4:0];
			end
			if (req.rd & (req.addr == SSPS_OFF_DATA)) begin
				n.stat[SSPS_ST_FULL] = 1'b0;
			end
			if (hit(req, SSPS_OFF_DATA) & (r.fsm == SSPS_IDLE)) begin
				n.tx_sh = {req.wdata, 1'b1};
				if (~r.master) begin
					n.sdo = req.wdata[7];
				end else if (r.i2c & r.stat[SSPS_ST_START]) begin
					// another master holds the bus
					iset[SSPS_IRQ_ARBL] = 1'b1;
				end else if (r.en) begin
					n.fsm = r.i2c ? SSPS_START : SSPS_SHIFT;
					n.h = 5'h00;
					n.div = 6'h00;
					n.nsamp = 4'h0;
					n.sck = r.i2c ? 1'b1 : r.clk_pol;
					n.sdo = r.i2c ? 1'b0 : req.wdata[7];
				end
			end
		end

		// I2C bus conditions, seen in every I2C role
		if (r.en & r.i2c & start_det) begin
			n.stat[SSPS_ST_START] = 1'b1;
			n.stat[SSPS_ST_STOP] = 1'b0;
			iset[SSPS_IRQ_START] = 1'b1;
		end
		if (r.en & r.i2c & stop_det) begin
			n.stat[SSPS_ST_STOP] = 1'b1;
			n.stat[SSPS_ST_START] = 1'b0;
			iset[SSPS_IRQ_STOP] = 1'b1;
		end

		case (r.fsm)
			SSPS_IDLE: begin
				if (r.master) begin
					n.sck = r.i2c ? 1'b1 : r.clk_pol;
				end
				if (r.en & ~r.i2c & ~r.master) begin
					if (in_e) begin
						n.rx_sh = {r.rx_sh[7:0], din};
						n.nsamp = r.nsamp + 4'h1;
						if (r.nsamp == 4'h7) begin
							n.nsamp = 4'h0;
							n.rx_buf = {r.rx_sh[6:0], din};
							n.stat[SSPS_ST_FULL] = 1'b1;
							iset[SSPS_IRQ_DONE] = 1'b1;
						end
					end
					if (out_e & (r.nsamp != 4'h0)) begin
						n.tx_sh = {r.tx_sh[7:0], 1'b1};
						n.sdo = r.tx_sh[7];
					end
				end
				if (r.en & r.i2c & ~r.master) begin
					if (start_det) begin
						n.sl_act = 1'b1;
						n.sl_addr = 1'b1;
						n.sl_cnt = 4'h0;
						n.sl_ack = 1'b0;
					end else if (stop_det) begin
						n.sl_act = 1'b0;
						n.sl_ack = 1'b0;
					end else if (r.sl_act & scl_rise & (r.sl_cnt < 4'h8)) begin
						n.rx_sh = {r.rx_sh[7:0], din};
						n.sl_cnt = r.sl_cnt + 4'h1;
					end else if (r.sl_act & scl_fall & (r.sl_cnt == 4'h8)) begin
						n.sl_cnt = 4'h9;
						if (~r.sl_addr | match) begin
							n.sl_ack = ~(r.stat[SSPS_ST_RDWR] & ~r.sl_addr);
							n.stat[SSPS_ST_DATA] = ~r.sl_addr;
							if (r.sl_addr) begin
								n.stat[SSPS_ST_RDWR] = r.rx_sh[0];
							end
							n.rx_buf = r.rx_sh[7:0];
							n.stat[SSPS_ST_FULL] = 1'b1;
							iset[SSPS_IRQ_DONE] = 1'b1;
						end else begin
							n.sl_act = 1'b0;
						end
					end else if (r.sl_act & scl_fall & (r.sl_cnt == 4'h9)) begin
						n.sl_ack = 1'b0;
						n.sl_cnt = 4'h0;
						n.sl_addr = 1'b0;
					end
				end
			end
			SSPS_START: begin
				n.div = r.div + 6'h01;
				if (tick) begin
					n.div = 6'h00;
					n.sck = 1'b0;
					n.sdo = r.tx_sh[8];
					n.fsm = SSPS_SHIFT;
				end
			end
			SSPS_SHIFT: begin
				n.div = r.div + 6'h01;
				if (tick) begin
					n.div = 6'h00;
					n.h = r.h + 5'h01;
					if (r.i2c | (r.h < SSPS_LAST_SPI_E)) begin
						n.sck = ~r.sck;
					end
					if (samp) begin
						n.rx_sh = rx_new;
						n.nsamp = r.nsamp + 4'h1;
					end
					if (bnd & ~first & (r.h != last_h)) begin
						n.tx_sh = {r.tx_sh[7:0], 1'b1};
						n.sdo = r.tx_sh[7];
					end
					if (r.i2c & samp & r.sdo & ~din & (r.nsamp < 4'h8)) begin
						// lost arbitration: release both lines at once
						n.fsm = SSPS_IDLE;
						n.sck = 1'b1;
						n.sdo = 1'b1;
						iset[SSPS_IRQ_ARBL] = 1'b1;
					end else if (r.h == last_h) begin
						if (r.i2c) begin
							n.fsm = SSPS_STOP;
							n.h = 5'h00;
							n.sdo = 1'b0;
							n.rx_buf = rx_new[8:1];
							iset[SSPS_IRQ_NACK] = rx_new[0];
						end else begin
							n.fsm = SSPS_IDLE;
							n.rx_buf = rx_new[7:0];
							n.stat[SSPS_ST_FULL] = 1'b1;
							iset[SSPS_IRQ_DONE] = 1'b1;
						end
					end
				end
			end
			SSPS_STOP: begin
				n.div = r.div + 6'h01;
				if (tick) begin
					n.div = 6'h00;
					n.h = 5'h01;
					n.sck = 1'b1;
					if (r.h != 5'h00) begin
						n.sdo = 1'b1;
						n.fsm = SSPS_IDLE;
						n.stat[SSPS_ST_FULL] = 1'b1;
						iset[SSPS_IRQ_DONE] = 1'b1;
					end
				end
			end
			default: n.fsm = SSPS_IDLE;
		endcase

		if (~r.en) begin
			n.fsm = SSPS_IDLE;
			n.stat[SSPS_ST_STOP] = 1'b0;
			n.stat[SSPS_ST_START] = 1'b0;
			n.sl_act = 1'b0;
			n.sl_ack = 1'b0;
			n.nsamp = 4'h0;
		end
		// an event in the cycle of its clear still lands
		n.irq_st = n.irq_st | iset;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			r <= '0;
			r.stat <= SSPS_STATUS_RST;
			r.ctrl2 <= SSPS_CTRL2_RST;
		end else if (CE) begin
			r <= n;
		end
	end

	assign AVS_READDATA = r.rdata;
	assign AVS_WAITREQUEST = (req.rd | req.wr) & ~r.ack;
	assign IRQ = |(r.irq_st & r.irq_en);
	assign SCK_SCL_OUT = r.i2c ? 1'b0 : r.sck;
	assign SCK_SCL_OE = r.en & (r.i2c ? ((r.fsm != SSPS_IDLE) & ~r.sck) : r.master);
	assign SDA_OUT = 1'b0;
	assign SDA_OE = r.en & r.i2c & (((r.fsm != SSPS_IDLE) & ~r.sdo) | r.sl_ack);
	assign SDO = r.sdo;
	assign SDO_OE = r.en & ~r.i2c;

	////////////////////////////////////////////////////////////////////////
	mode_excl_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!(SDO_OE && SDA_OE) && ((r.fsm != SSPS_IDLE) -> r.master))
		else $error("both protocols driving");
	slave_ack_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(r.sl_ack) |-> r.stat[SSPS_ST_FULL] && r.irq_st[SSPS_IRQ_DONE])
		else $error("slave acked without a byte");
	sample_time_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(CE && r.fsm == SSPS_SHIFT && !r.i2c && tick && (r.stat[SSPS_ST_SAMPLE] ? !bnd : bnd))
		|=> $stable(r.nsamp))
		else $error("spi sampled at wrong time");
	shift_edge_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(r.fsm == SSPS_SHIFT && $past(r.fsm) == SSPS_SHIFT && !r.i2c && $changed(r.tx_sh))
		|-> $changed(r.sck) && r.sck == (r.stat[SSPS_ST_EDGE] ^ r.clk_pol))
		else $error("data shifted on wrong edge");
	status_wr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(CE && commit && hit(req, SSPS_OFF_STATUS)) |=> r.stat[7:6] == $past(req.wdata[7:6]))
		else $error("status write lost");
	ctrl_wr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(CE && commit && hit(req, SSPS_OFF_CTRL1)) |=> r.en == $past(req.wdata[0])
		&& r.i2c == $past(req.wdata[1]))
		else $error("control write lost");
	flag_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(CE && !r.en) |=> !r.stat[SSPS_ST_STOP] && !r.stat[SSPS_ST_START])
		else $error("bus flags kept while disabled");
	start_seen_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(CE && r.en && r.i2c && start_det) |=> r.stat[SSPS_ST_START] && !r.stat[SSPS_ST_STOP])
		else $error("start not flagged");
endmodule : ssps_port

// [ssps_spi_peer.sv]
/*
 * behavioural SPI peripheral standing on the far side of the port.
 * assumes the bench tells it which clock edge shifts and pulses rearm
 * before every frame; there is no slave select on this link.
 */
`timescale 1ns/1ps
module ssps_spi_peer (
	input wire logic sck,
	input wire logic shift_rise,
	input wire logic rearm,
	input wire logic [7:0] tx_byte,
	input wire logic mosi,
	output logic miso,
	output logic [7:0] rx_byte
);
	logic [2:0] ptr;
	logic [3:0] cnt;
	logic sampled;
	logic past;
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge sck or negedge sck or posedge rearm) begin
		if (rearm) begin
			ptr = 3'h7;
			cnt = 4'h0;
			sampled = 1'b0;
			past = 1'b0;
			rx_byte = 8'h00;
		end else if (sck == shift_rise) begin
			// a shift edge ahead of any sample still belongs to the first bit
			if (sampled && ptr != 3'h0) begin
				ptr = ptr - 3'h1;
				sampled = 1'b0;
			end else if (sampled && cnt >= 4'h8) begin
				// only the shift edge after the eighth sample ends the frame
				past = 1'b1;
			end
		end else begin
			rx_byte = {rx_byte[6:0], mosi};
			cnt = cnt + 4'h1;
			sampled = 1'b1;
		end
	end
	// after the frame the line no longer holds the last bit
	assign miso = past ? ~tx_byte[0] : tx_byte[ptr];
endmodule : ssps_spi_peer

// [sync_serial_port_status_tb_top.sv]
/*
 * self-checking bench for the synchronous serial port: registers, SPI
 * master rows against the peer model, SPI slave, I2C bus conditions.
 * assumes open-drain lines pulled up; the bench makes the slave clock.
 */
`timescale 1ns/1ps
module sync_serial_port_status_tb_top import ssps_pkg::*;;
	typedef struct packed {
		logic pol;
		logic edge_sel;
		logic late;
		logic [7:0] tx;
		logic [7:0] rx;
	} ssps_row_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, irq, scl_out, scl_oe, sda_out, sda_oe, sdo, sdo_oe, model_sdi;
	logic bench_scl = 1'b0;
	logic bench_sda = 1'b1;
	logic bench_sdi = 1'b0;
	logic use_bench_sdi = 1'b0;
	logic rearm = 1'b0;
	logic shift_rise = 1'b0;
	logic [7:0] peer_tx = 8'h00;
	logic [7:0] slv_byte = 8'h96;
	logic [7:0] slv_adr = 8'h54;
	logic ce = 1'b1;
	logic [3:0] avs_be = 4'h1;
	logic [7:0] model_rx;
	logic [7:0] rd;
	int failures = 0;
	int check_count = 0;
	ssps_row_t rows [4];
	wire scl_line = scl_oe ? scl_out : bench_scl;
	wire sda_line = sda_oe ? 1'b0 : bench_sda;
	wire sdi_line = use_bench_sdi ? bench_sdi : model_sdi;
	////////////////////////////////////////////////////////////////////////////////
	ssps_port dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(ce), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_BYTEENABLE(avs_be),
		.AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq), .SCK_SCL_IN(scl_line),
		.SCK_SCL_OUT(scl_out), .SCK_SCL_OE(scl_oe), .SDA_IN(sda_line), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe), .SDI(sdi_line), .SDO(sdo), .SDO_OE(sdo_oe));
	ssps_spi_peer peer_u (.sck(scl_out), .shift_rise(shift_rise), .rearm(rearm),
		.tx_byte(peer_tx), .mosi(sdo), .miso(model_sdi), .rx_byte(model_rx));
	always #2.5 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (failures == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic bus(input logic wr, input logic [4:0] addr, input logic [7:0] wd,
		output logic [7:0] rdv);
		int n = 0;
		@(posedge sys_clk);
		avs_address <= addr;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, wd};
		// request holds until the edge that sees waitrequest low
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (avs_waitrequest !== 1'b0) begin
			failures++;
			final_report();
		end
		rdv = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic rchk(input logic [4:0] addr, input logic [7:0] exp);
		logic [7:0] v;
		bus(1'b0, addr, 8'h00, v);
		chk8(v, exp);
	endtask : rchk
	task automatic irq_is(input logic exp);
		@(negedge sys_clk);
		chk8({7'h00, irq}, {7'h00, exp});
	endtask : irq_is
	task automatic line(input logic scl, input logic sda);
		@(posedge sys_clk);
		bench_scl <= scl;
		bench_sda <= sda;
		repeat (20) @(posedge sys_clk);
	endtask : line
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		rows[0] = '{1'b0, 1'b0, 1'b0, 8'hA5, 8'h3C};
		rows[1] = '{1'b0, 1'b1, 1'b1, 8'h81, 8'h7E};
		rows[2] = '{1'b1, 1'b0, 1'b1, 8'h5A, 8'hC3};
		rows[3] = '{1'b1, 1'b1, 1'b0, 8'h01, 8'hFF};
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 8; a++) rchk(5'(a * 4), 8'h00);
		bus(1'b1, SSPS_OFF_STATUS, 8'hFF, rd);
		rchk(SSPS_OFF_STATUS, 8'hC0);
		bus(1'b1, 5'h1C, 8'hFF, rd);
		rchk(5'h1C, 8'h00);
		bus(1'b1, SSPS_OFF_CTRL2, 8'h2A, rd);
		rchk(SSPS_OFF_CTRL2, 8'h2A);
		avs_be <= 4'h0;
		bus(1'b1, SSPS_OFF_CTRL2, 8'h55, rd);
		avs_be <= 4'h1;
		rchk(SSPS_OFF_CTRL2, 8'h2A);
		bus(1'b1, SSPS_OFF_IRQ_EN, 8'h01, rd);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, SSPS_OFF_STATUS, {rows[i].late, rows[i].edge_sel, 6'h00}, rd);
			bus(1'b1, SSPS_OFF_CTRL1, {4'h0, rows[i].pol, 3'h5}, rd);
			shift_rise <= rows[i].edge_sel ^ rows[i].pol;
			peer_tx <= rows[i].rx;
			@(posedge sys_clk);
			rearm <= 1'b1;
			chk8({6'h00, scl_oe, sdo_oe}, 8'h03);
			@(posedge sys_clk);
			rearm <= 1'b0;
			bus(1'b1, SSPS_OFF_DATA, rows[i].tx, rd);
			n = 0;
			while (irq !== 1'b1 && n < 2000) begin
				@(posedge sys_clk);
				n++;
			end
			if (n == 2000) begin
				failures++;
				final_report();
			end
			chk8(model_rx, rows[i].tx);
			rchk(SSPS_OFF_STATUS, {rows[i].late, rows[i].edge_sel, 6'h01});
			rchk(SSPS_OFF_DATA, rows[i].rx);
			rchk(SSPS_OFF_STATUS, {rows[i].late, rows[i].edge_sel, 6'h00});
			bus(1'b1, SSPS_OFF_IRQ_CLR, 8'h01, rd);
			irq_is(1'b0);
		end
		// slave frame: sample bit kept clear, external clock at 160 ns
		bus(1'b1, SSPS_OFF_CTRL1, 8'h00, rd);
		bus(1'b1, SSPS_OFF_STATUS, 8'h00, rd);
		bus(1'b1, SSPS_OFF_CTRL1, 8'h01, rd);
		use_bench_sdi <= 1'b1;
		for (int b = 7; b >= 0; b--) begin
			bench_sdi <= slv_byte[b];
			repeat (16) @(posedge sys_clk);
			bench_scl <= 1'b1;
			repeat (16) @(posedge sys_clk);
			bench_scl <= 1'b0;
		end
		repeat (8) @(posedge sys_clk);
		rchk(SSPS_OFF_STATUS, 8'h01);
		rchk(SSPS_OFF_DATA, slv_byte);
		irq_is(1'b1);
		bus(1'b1, SSPS_OFF_IRQ_CLR, 8'h01, rd);
		// I2C slave watching bus conditions made by the bench
		bus(1'b1, SSPS_OFF_CTRL1, 8'h00, rd);
		bench_scl <= 1'b1;
		bus(1'b1, SSPS_OFF_IRQ_EN, 8'h00, rd);
		bus(1'b1, SSPS_OFF_CTRL1, 8'h03, rd);
		line(1'b1, 1'b0);
		rchk(SSPS_OFF_STATUS, 8'h08);
		rchk(SSPS_OFF_IRQ_STAT, 8'h02);
		irq_is(1'b0);
		bus(1'b1, SSPS_OFF_IRQ_EN, 8'h02, rd);
		irq_is(1'b1);
		bus(1'b1, SSPS_OFF_IRQ_CLR, 8'h02, rd);
		irq_is(1'b0);
		line(1'b0, 1'b0);
		line(1'b1, 1'b0);
		line(1'b1, 1'b1);
		rchk(SSPS_OFF_STATUS, 8'h10);
		// a start made while the clock enable is low waits for it
		ce <= 1'b0;
		line(1'b1, 1'b0);
		irq_is(1'b0);
		@(posedge sys_clk);
		ce <= 1'b1;
		repeat (8) @(posedge sys_clk);
		irq_is(1'b1);
		rchk(SSPS_OFF_STATUS, 8'h08);
		// address byte for the own address, acked on the ninth clock
		for (int b = 7; b >= 0; b--) begin
			line(1'b0, slv_adr[b]);
			line(1'b1, slv_adr[b]);
		end
		line(1'b0, 1'b1);
		chk8({4'h0, scl_oe, sda_out, sdo_oe, sda_oe}, 8'h01);
		rchk(SSPS_OFF_STATUS, 8'h09);
		line(1'b1, 1'b1);
		line(1'b0, 1'b1);
		chk8({4'h0, scl_oe, sda_out, sdo_oe, sda_oe}, 8'h00);
		rchk(SSPS_OFF_DATA, slv_adr);
		// a master write while another master holds the bus is refused
		bus(1'b1, SSPS_OFF_CTRL1, 8'h07, rd);
		bus(1'b1, SSPS_OFF_DATA, 8'hA0, rd);
		rchk(SSPS_OFF_IRQ_STAT, 8'h0F);
		chk8({6'h00, scl_oe, sda_oe}, 8'h00);
		bus(1'b1, SSPS_OFF_CTRL1, 8'h02, rd);
		rchk(SSPS_OFF_STATUS, 8'h00);
		final_report();
	end
endmodule : sync_serial_port_status_tb_top
